/* File: shared/ifsm_pkg.sv */
// shared constants, types and carriers of the interrupt flag and supply monitor block
package ifsm_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned MON_IRQ_DELAY_NS = 15000;
    localparam int unsigned MON_IRQ_DELAY_CYC = (MON_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DLY_W = 9;

    // ==========================================================
    // register indices on the special register port
    localparam logic [2:0] ADDR_CTRL_ZERO = 3'h0;
    localparam logic [2:0] ADDR_CTRL_ONE = 3'h1;
    localparam logic [2:0] ADDR_CTRL_TWO = 3'h2;
    localparam logic [2:0] ADDR_CTRL_THREE = 3'h3;
    localparam logic [2:0] ADDR_MFI_ZERO = 3'h4;
    localparam logic [2:0] ADDR_MFI_ONE = 3'h5;
    localparam logic [2:0] ADDR_EDGE_SEL = 3'h6;
    localparam logic [2:0] ADDR_MON_CTRL = 3'h7;

    // ==========================================================
    // field positions and masks
    localparam int unsigned GIE_BIT = 0;
    localparam int unsigned FLAG_LSB = 4;
    localparam int unsigned PIN0_FLAG_BIT = 4;
    localparam int unsigned PIN1_FLAG_BIT = 5;
    localparam int unsigned MON_DETECT_BIT = 5;
    localparam int unsigned MON_EN_BIT = 4;
    localparam int unsigned MON_REF_BIT = 3;
    localparam logic [7:0] CTRL_ZERO_MASK = 8'h7f;
    localparam logic [7:0] CTRL_THREE_MASK = 8'h11;
    localparam logic [7:0] FULL_MASK = 8'hff;
    localparam logic [3:0] EDGE_MASK = 4'hf;
    localparam logic [4:0] MON_WR_MASK = 5'h1f;

    // ==========================================================
    // reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [3:0] EDGE_RST = 4'h0;
    localparam logic [4:0] MON_RST = 5'h00;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } ifsm_edge_e;

    // vector sources that the core may acknowledge
    typedef enum logic [3:0] {
        SRC_PIN0 = 4'h0,
        SRC_PIN1 = 4'h1,
        SRC_SIM = 4'h2,
        SRC_SECOND_SPI = 4'h3,
        SRC_UART = 4'h4,
        SRC_MF0 = 4'h5,
        SRC_MF1 = 4'h6,
        SRC_TB0 = 4'h7,
        SRC_TB1 = 4'h8,
        SRC_ADC = 4'h9,
        SRC_EEPROM = 4'ha,
        SRC_LOWV = 4'hb
    } ifsm_src_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ifsm_bus_s;

    // one-cycle event pulses from the peripherals
    typedef struct packed {
        logic serial_module;
        logic second_spi_port;
        logic uart;
        logic time_base0;
        logic time_base1;
        logic converter;
        logic eeprom_write;
        logic [2:0] periodic_timer_period;
        logic [2:0] periodic_timer_match;
        logic standard_timer_period;
        logic standard_timer_match;
    } ifsm_evt_s;

    typedef struct packed {
        logic ack;
        ifsm_src_e src;
    } ifsm_svc_s;

    typedef struct packed {
        logic power_on;
        logic reference_output_enable;
        logic [2:0] threshold_code;
    } ifsm_mon_s;

endpackage

/* File: src/ifsm_lv_mon.sv */
// supply monitor comparator sampling, detect flag and delayed interrupt event
`timescale 1ns/1ps
module ifsm_lv_mon (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmp_low,
    input wire logic enable,
    output logic detect,
    output logic irq_evt
);
    import ifsm_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic detect;
        logic [DLY_W-1:0] cnt;
        logic fired;
        logic evt;
    } ifsm_lm_s;

    ifsm_lm_s st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = cmp_low;
        st_nxt.s2 = st_r.s1;
        // a powered-down comparator reports nothing
        st_nxt.detect = enable & st_r.s2;
        st_nxt.evt = 1'b0;
        if (!st_r.detect) begin
            st_nxt.cnt = '0;
            st_nxt.fired = 1'b0;
        end else if (!st_r.fired) begin
            // one event per low-supply episode, however long it lasts
            if (st_r.cnt == DLY_W'(MON_IRQ_DELAY_CYC - 1)) begin
                st_nxt.evt = 1'b1;
                st_nxt.fired = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + DLY_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign detect = st_r.detect;
    assign irq_evt = st_r.evt;
endmodule

/* File: src/ifsm_pin_edge.sv */
// synchroniser and selectable edge detector for one external interrupt pin
`timescale 1ns/1ps
module ifsm_pin_edge (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    input wire ifsm_pkg::ifsm_edge_e edge_sel,
    output logic hit
);
    import ifsm_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic hit;
    } ifsm_pe_s;

    ifsm_pe_s st_r, st_nxt;

    always_comb begin
        logic rise;
        logic fall;
        rise = st_r.s2 & ~st_r.prev;
        fall = ~st_r.s2 & st_r.prev;
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        unique case (edge_sel)
            EDGE_OFF: st_nxt.hit = 1'b0;
            EDGE_RISE: st_nxt.hit = rise;
            EDGE_FALL: st_nxt.hit = fall;
            EDGE_BOTH: st_nxt.hit = rise | fall;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hit = st_r.hit;
endmodule

/* File: src/ifsm_top.sv */
// interrupt enables, request flags, edge selection and supply monitor control
`timescale 1ns/1ps
module ifsm_top (
    clk,
    rstn,
    bus,
    rdata,
    ext_pin,
    evt,
    svc,
    cmp_low,
    mon,
    irq_req,
    irq_pending,
    wake_req
);
    import ifsm_pkg::*;

    input wire logic clk;
    input wire logic rstn;
    input wire ifsm_pkg::ifsm_bus_s bus;
    output logic [7:0] rdata;
    input wire logic [1:0] ext_pin;
    input wire ifsm_pkg::ifsm_evt_s evt;
    input wire ifsm_pkg::ifsm_svc_s svc;
    input wire logic cmp_low;
    output ifsm_pkg::ifsm_mon_s mon;
    output logic irq_req;
    output logic [11:0] irq_pending;
    output logic wake_req;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] multi_func_irq_zero;
        logic [7:0] multi_func_irq_one;
        logic [3:0] edge_sel;
        logic [4:0] mon_ctl;
        logic [7:0] rdata;
        logic irq;
        logic [11:0] pending;
        logic wake;
    } ifsm_st_s;

    localparam ifsm_st_s ST_RST = '{
        ctrl0: REG_RST,
        ctrl1: REG_RST,
        ctrl2: REG_RST,
        ctrl3: REG_RST,
        multi_func_irq_zero: REG_RST,
        multi_func_irq_one: REG_RST,
        edge_sel: EDGE_RST,
        mon_ctl: MON_RST,
        rdata: REG_RST,
        irq: 1'b0,
        pending: '0,
        wake: 1'b0
    };

    ifsm_st_s st_r, st_nxt;

    logic [1:0] pin_hit;
    logic lv_detect;
    logic lv_evt;

    // ==========================================================
    // external pins
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            ifsm_pin_edge u_edge (
                .clk(clk),
                .rstn(rstn),
                .pin(ext_pin[gi]),
                .edge_sel(ifsm_edge_e'(st_r.edge_sel[2*gi +: 2])),
                .hit(pin_hit[gi])
            );
        end
    endgenerate

    // ==========================================================
    // supply monitor
    ifsm_lv_mon u_lv_mon (
        .clk(clk),
        .rstn(rstn),
        .cmp_low(cmp_low),
        .enable(st_r.mon_ctl[MON_EN_BIT]),
        .detect(lv_detect),
        .irq_evt(lv_evt)
    );

    // ==========================================================
    // flag byte update: software write first, then hardware clear, then
    // hardware set, so an event in the clearing cycle still lands
    function automatic logic [7:0] upd(
        input logic [7:0] old,
        input logic we,
        input logic [7:0] wd,
        input logic [7:0] mask,
        input logic [3:0] set,
        input logic [3:0] hw_clr
    );
        logic [7:0] v;
        v = we ? (wd & mask) : old;
        v[7:4] = (v[7:4] & ~hw_clr) | set;
        return v & mask;
    endfunction

    function automatic logic wr_hit(input ifsm_bus_s b, input logic [2:0] a);
        return b.wr && (b.addr == a);
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic [3:0] set0;
        logic [3:0] set1;
        logic [3:0] set2;
        logic [3:0] set3;
        logic [3:0] setm0;
        logic [3:0] setm1;
        logic [3:0] pin_clr;
        logic mf0_hit;
        logic mf1_hit;
        logic [11:0] pend;
        set0 = '0;
        set1 = '0;
        set2 = '0;
        set3 = '0;
        setm0 = '0;
        setm1 = '0;
        pin_clr = '0;
        mf0_hit = 1'b0;
        mf1_hit = 1'b0;
        pend = '0;
        st_nxt = st_r;

        // group registers first, their summaries feed control one
        setm0 = {evt.periodic_timer_match[1], evt.periodic_timer_period[1],
                 evt.periodic_timer_match[0], evt.periodic_timer_period[0]};
        setm1 = {evt.standard_timer_match, evt.standard_timer_period,
                 evt.periodic_timer_match[2], evt.periodic_timer_period[2]};
        st_nxt.multi_func_irq_zero = upd(st_r.multi_func_irq_zero, wr_hit(bus, ADDR_MFI_ZERO), bus.wdata, FULL_MASK, setm0, 4'h0);
        st_nxt.multi_func_irq_one = upd(st_r.multi_func_irq_one, wr_hit(bus, ADDR_MFI_ONE), bus.wdata, FULL_MASK, setm1, 4'h0);

        // summary rises only when a new enabled request appears
        mf0_hit = (|(st_nxt.multi_func_irq_zero[7:4] & st_nxt.multi_func_irq_zero[3:0])) & ~(|(st_r.multi_func_irq_zero[7:4] & st_r.multi_func_irq_zero[3:0]));
        mf1_hit = (|(st_nxt.multi_func_irq_one[7:4] & st_nxt.multi_func_irq_one[3:0])) & ~(|(st_r.multi_func_irq_one[7:4] & st_r.multi_func_irq_one[3:0]));

        // servicing a pin clears its flag
        if (svc.ack && svc.src == SRC_PIN0) begin
            pin_clr[PIN0_FLAG_BIT - FLAG_LSB] = 1'b1;
        end
        if (svc.ack && svc.src == SRC_PIN1) begin
            pin_clr[PIN1_FLAG_BIT - FLAG_LSB] = 1'b1;
        end

        set0 = {1'b0, evt.serial_module, pin_hit[1], pin_hit[0]};
        set1 = {mf1_hit, mf0_hit, evt.uart, evt.second_spi_port};
        set2 = {evt.eeprom_write, evt.converter, evt.time_base1, evt.time_base0};
        set3 = {3'b000, lv_evt};

        st_nxt.ctrl0 = upd(st_r.ctrl0, wr_hit(bus, ADDR_CTRL_ZERO), bus.wdata, CTRL_ZERO_MASK, set0, pin_clr);
        st_nxt.ctrl1 = upd(st_r.ctrl1, wr_hit(bus, ADDR_CTRL_ONE), bus.wdata, FULL_MASK, set1, 4'h0);
        st_nxt.ctrl2 = upd(st_r.ctrl2, wr_hit(bus, ADDR_CTRL_TWO), bus.wdata, FULL_MASK, set2, 4'h0);
        st_nxt.ctrl3 = upd(st_r.ctrl3, wr_hit(bus, ADDR_CTRL_THREE), bus.wdata, CTRL_THREE_MASK, set3, 4'h0);

        // taking any vector blocks nesting until software re-enables
        if (svc.ack) begin
            st_nxt.ctrl0[GIE_BIT] = 1'b0;
        end

        if (wr_hit(bus, ADDR_EDGE_SEL)) begin
            st_nxt.edge_sel = bus.wdata[3:0] & EDGE_MASK;
        end
        if (wr_hit(bus, ADDR_MON_CTRL)) begin
            st_nxt.mon_ctl = bus.wdata[4:0] & MON_WR_MASK;
        end

        // per-source enabled requests, in vector order
        pend[SRC_PIN0] = st_nxt.ctrl0[4] & st_nxt.ctrl0[1];
        pend[SRC_PIN1] = st_nxt.ctrl0[5] & st_nxt.ctrl0[2];
        pend[SRC_SIM] = st_nxt.ctrl0[6] & st_nxt.ctrl0[3];
        pend[SRC_SECOND_SPI] = st_nxt.ctrl1[4] & st_nxt.ctrl1[0];
        pend[SRC_UART] = st_nxt.ctrl1[5] & st_nxt.ctrl1[1];
        pend[SRC_MF0] = st_nxt.ctrl1[6] & st_nxt.ctrl1[2];
        pend[SRC_MF1] = st_nxt.ctrl1[7] & st_nxt.ctrl1[3];
        pend[SRC_TB0] = st_nxt.ctrl2[4] & st_nxt.ctrl2[0];
        pend[SRC_TB1] = st_nxt.ctrl2[5] & st_nxt.ctrl2[1];
        pend[SRC_ADC] = st_nxt.ctrl2[6] & st_nxt.ctrl2[2];
        pend[SRC_EEPROM] = st_nxt.ctrl2[7] & st_nxt.ctrl2[3];
        pend[SRC_LOWV] = st_nxt.ctrl3[4] & st_nxt.ctrl3[0];
        st_nxt.pending = pend;
        st_nxt.irq = st_nxt.ctrl0[GIE_BIT] & (|pend);

        // any set flag in control zero to three wakes, enabled or not; the monitor keeps running
        st_nxt.wake = (|st_nxt.ctrl0[6:4]) | (|st_nxt.ctrl1[7:4])
                    | (|st_nxt.ctrl2[7:4]) | st_nxt.ctrl3[4];

        // read data, held until the next read
        if (bus.rd) begin
            unique case (bus.addr)
                ADDR_CTRL_ZERO: st_nxt.rdata = st_r.ctrl0 & CTRL_ZERO_MASK;
                ADDR_CTRL_ONE: st_nxt.rdata = st_r.ctrl1;
                ADDR_CTRL_TWO: st_nxt.rdata = st_r.ctrl2;
                ADDR_CTRL_THREE: st_nxt.rdata = st_r.ctrl3 & CTRL_THREE_MASK;
                ADDR_MFI_ZERO: st_nxt.rdata = st_r.multi_func_irq_zero;
                ADDR_MFI_ONE: st_nxt.rdata = st_r.multi_func_irq_one;
                ADDR_EDGE_SEL: st_nxt.rdata = {4'h0, st_r.edge_sel};
                ADDR_MON_CTRL: st_nxt.rdata = {2'b00, lv_detect, st_r.mon_ctl};
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // outputs, all straight from state flops
    assign rdata = st_r.rdata;
    assign irq_req = st_r.irq;
    assign irq_pending = st_r.pending;
    assign wake_req = st_r.wake;
    assign mon.power_on = st_r.mon_ctl[MON_EN_BIT];
    assign mon.reference_output_enable = st_r.mon_ctl[MON_REF_BIT];
    assign mon.threshold_code = st_r.mon_ctl[2:0];
endmodule

/* File: tb/ifsm_core_model.sv */
// processor core model: special register accesses and service handshake
`timescale 1ns/1ps
module ifsm_core_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output ifsm_pkg::ifsm_bus_s bus,
    output ifsm_pkg::ifsm_svc_s svc
);
    import ifsm_pkg::*;
    initial begin
        bus = '0;
        svc = '{ack: 1'b0, src: SRC_PIN0};
    end
    // each access ends with an idle cycle so strobes never toggle twice in one step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 bus.wr = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 bus.rd = 1'b0;
        d = rdata;
        @(posedge clk);
        #1;
    endtask
    task automatic ack(input ifsm_src_e s);
        svc = '{ack: 1'b1, src: s};
        @(posedge clk);
        #1 svc.ack = 1'b0;
        @(posedge clk);
        #1;
    endtask
endmodule

/* File: tb/ifsm_props.sv */
// concurrent checks on the ports of the interrupt flag and supply monitor block
`timescale 1ns/1ps
module ifsm_props (
    input wire logic clk,
    input wire logic rstn,
    input wire ifsm_pkg::ifsm_bus_s bus,
    input wire logic [7:0] rdata,
    input wire ifsm_pkg::ifsm_evt_s evt,
    input wire ifsm_pkg::ifsm_svc_s svc,
    input wire ifsm_pkg::ifsm_mon_s mon,
    input wire logic irq_req,
    input wire logic [11:0] irq_pending,
    input wire logic wake_req
);
    import ifsm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // register port
    mon_write_a: assert property (bus.wr && bus.addr == ADDR_MON_CTRL |=> mon == $past(bus.wdata[4:0]))
        else $error("monitor outputs differ from written control bits");
    mon_hold_a: assert property (!(bus.wr && bus.addr == ADDR_MON_CTRL) |=> $stable(mon))
        else $error("monitor outputs moved without a write");
    edge_rsvd_a: assert property (bus.rd && bus.addr == ADDR_EDGE_SEL |=> rdata[7:4] == 4'h0)
        else $error("edge register upper bits not zero");
    ctrl_zero_rsvd_a: assert property (bus.rd && bus.addr == ADDR_CTRL_ZERO |=> !rdata[7])
        else $error("control zero bit 7 not zero");
    ctrl_three_rsvd_a: assert property (bus.rd && bus.addr == ADDR_CTRL_THREE |=> (rdata & ~CTRL_THREE_MASK) == 8'h00)
        else $error("control three unused bits not zero");
    mon_read_a: assert property (bus.rd && bus.addr == ADDR_MON_CTRL |=>
        rdata[7:6] == 2'b00 && rdata[4:0] == $past(mon))
        else $error("monitor register read mismatch");
    // ==========================================================
    // request and service
    global_gate_a: assert property (irq_req |-> irq_pending != 12'h000)
        else $error("request raised with nothing enabled pending");
    svc_clear_a: assert property (svc.ack |=> !irq_req)
        else $error("request still high after service began");
    flag_set_a: assert property (evt.uart |=> wake_req)
        else $error("event did not record a request flag");
endmodule
bind ifsm_top ifsm_props u_props (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .evt(evt), .svc(svc), .mon(mon),
    .irq_req(irq_req), .irq_pending(irq_pending), .wake_req(wake_req));

/* File: tb/tb_top.sv */
// self-checking bench for the interrupt flag and supply monitor block
`timescale 1ns/1ps
module tb_top;
    import ifsm_pkg::*;
    logic clk;
    logic rstn;
    logic [1:0] ext_pin;
    ifsm_evt_s evt;
    logic cmp_low;
    ifsm_bus_s bus;
    ifsm_svc_s svc;
    logic [7:0] rdata;
    ifsm_mon_s mon;
    logic irq_req;
    logic [11:0] irq_pending;
    logic wake_req;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    // rows: {address, written byte, expected readback}
    logic [23:0] rows [8] = '{24'h00ff7f, 24'h01ffff, 24'h02a5a5, 24'h03ff11,
        24'h045a5a, 24'h05c3c3, 24'h06ff0f, 24'h07ff1f};
    ifsm_top uut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .ext_pin(ext_pin), .evt(evt), .svc(svc),
        .cmp_low(cmp_low), .mon(mon), .irq_req(irq_req), .irq_pending(irq_pending), .wake_req(wake_req));
    ifsm_core_model u_core (.clk(clk), .rdata(rdata), .bus(bus), .svc(svc));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // helpers
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_core.rd(a, v);
        chk({4'h0, v}, {4'h0, exp});
    endtask
    // event bits: [12] uart, [5] timer 0 period, [0] standard timer match
    task automatic fire(input ifsm_evt_s e);
        evt = e;
        @(posedge clk);
        #1 evt = '0;
        @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        int p;
        logic [1:0] code;
        rstn = 1'b0;
        ext_pin = 2'b00;
        evt = '0;
        cmp_low = 1'b0;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        for (int a = 0; a < 8; a++) rchk(3'(a), REG_RST);
        for (int i = 0; i < 8; i++) begin
            u_core.wr(rows[i][18:16], rows[i][15:8]);
            rchk(rows[i][18:16], rows[i][7:0]);
        end
        for (int a = 0; a < 8; a++) u_core.wr(3'(a), 8'h00);
        // every edge code on both pins, rising then falling
        for (int i = 0; i < 8; i++) begin
            p = i[2];
            code = i[1:0];
            u_core.wr(ADDR_EDGE_SEL, 8'(code) << (2 * p));
            ext_pin[p] = 1'b1;
            repeat (4) @(posedge clk);
            #1;
            rchk(ADDR_CTRL_ZERO, 8'(code[0]) << (4 + p));
            u_core.wr(ADDR_CTRL_ZERO, 8'h00);
            ext_pin[p] = 1'b0;
            repeat (4) @(posedge clk);
            #1;
            rchk(ADDR_CTRL_ZERO, 8'(code[1]) << (4 + p));
            u_core.wr(ADDR_CTRL_ZERO, 8'h00);
        end
        // flag without global enable, then gating and service
        u_core.wr(ADDR_CTRL_ONE, 8'h02);
        fire(15'h1000);
        chk({11'h0, irq_req}, 12'h000);
        chk(irq_pending, 12'h010);
        chk({11'h0, wake_req}, 12'h001);
        u_core.wr(ADDR_CTRL_ZERO, 8'h01);
        chk({11'h0, irq_req}, 12'h001);
        u_core.ack(SRC_UART);
        chk({11'h0, irq_req}, 12'h000);
        rchk(ADDR_CTRL_ZERO, 8'h00);
        u_core.wr(ADDR_CTRL_ZERO, 8'h13);
        u_core.ack(SRC_PIN0);
        rchk(ADDR_CTRL_ZERO, 8'h02);
        u_core.wr(ADDR_CTRL_ZERO, 8'h22);
        u_core.ack(SRC_PIN1);
        rchk(ADDR_CTRL_ZERO, 8'h02);
        u_core.wr(ADDR_CTRL_ONE, 8'h00);
        // group summaries and the remaining sources
        u_core.wr(ADDR_MFI_ZERO, 8'h01);
        fire(15'h0020);
        rchk(ADDR_CTRL_ONE, 8'h40);
        rchk(ADDR_MFI_ZERO, 8'h11);
        u_core.wr(ADDR_MFI_ONE, 8'h08);
        fire(15'h0001);
        rchk(ADDR_CTRL_ONE, 8'hc0);
        fire(15'h6f00);
        rchk(ADDR_CTRL_ZERO, 8'h42);
        rchk(ADDR_CTRL_ONE, 8'hd0);
        rchk(ADDR_CTRL_TWO, 8'hf0);
        // supply monitor: detect, delayed flag, switch off
        u_core.wr(ADDR_MON_CTRL, 8'h15);
        chk({7'h0, mon}, 12'h015);
        repeat (20) @(posedge clk);
        #1 cmp_low = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rchk(ADDR_MON_CTRL, 8'h35);
        repeat (MON_IRQ_DELAY_CYC - 10) @(posedge clk);
        #1;
        rchk(ADDR_CTRL_THREE, 8'h00);
        repeat (10) @(posedge clk);
        #1;
        rchk(ADDR_CTRL_THREE, 8'h10);
        chk({11'h0, wake_req}, 12'h001);
        cmp_low = 1'b0;
        u_core.wr(ADDR_MON_CTRL, 8'h00);
        rchk(ADDR_MON_CTRL, 8'h00);
        // software clears and then presets the low-supply flag, which reads back set
        u_core.wr(ADDR_CTRL_THREE, 8'h00);
        rchk(ADDR_CTRL_THREE, 8'h00);
        u_core.wr(ADDR_CTRL_THREE, 8'h10);
        rchk(ADDR_CTRL_THREE, 8'h10);
        // reset in mid-run clears every flag and request
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        chk({11'h0, wake_req}, 12'h000);
        rchk(ADDR_CTRL_TWO, 8'h00);
        rchk(ADDR_CTRL_THREE, 8'h00);
        stop_test();
    end
endmodule
